// ===== verilog/vpl_top.sv
// vpl_top: vector priority, low-voltage supervisor control and clock output
//
// Added by the designer: the placing of the registers and the plain strobed port.
`default_nettype none

module vpl_top (
	// clock and reset
	input  wire logic        CORE_CLK_I,
	input  wire logic        RST_N_I,
	// register port
	input  wire logic [7:0]  ADDR_I,
	input  wire logic [7:0]  WDATA_I,
	input  wire logic        WR_I,
	input  wire logic        RD_I,
	output logic      [7:0]  RDATA_O,
	// peripheral sources and local enables, bit n is vector n
	input  wire logic [31:0] SRC_FLAG_I,
	input  wire logic [31:0] SRC_EN_I,
	// core vector fetch
	input  wire logic [15:0] FETCH_ADDR_I,
	input  wire logic        FETCH_I,
	output logic      [7:0]  FETCH_DATA_O,
	output logic             CPU_IRQ_O,
	output logic      [4:0]  CPU_VEC_O,
	// analog supervisor
	input  wire logic        POR_I,
	input  wire logic        LV_DETECT_I,
	input  wire logic        LV_WARN_I,
	output logic             SUP_ON_O,
	output logic             THRESH_SEL_O,
	output logic             SYS_RST_O,
	output logic      [1:0]  STOP_MODE_O,
	// shared port pin
	input  wire logic        PORT_OUT_I,
	input  wire logic        PORT_DIR_I,
	input  wire logic        PIN_SLEW_EN_I,
	input  wire logic        PIN_DRIVE_I,
	output logic             PIN_OUT_O,
	output logic             PIN_OE_O,
	output logic             PIN_SLEW_O,
	output logic             PIN_DRIVE_O,
	// summary interrupt
	output logic             INT_O
);

	// local names for the package mode literals, nothing is imported
	localparam vpl_pkg::vpl_mode_t VPL_RUN     = vpl_pkg::VPL_RUN;
	localparam vpl_pkg::vpl_mode_t VPL_LV_HOLD = vpl_pkg::VPL_LV_HOLD;
	localparam vpl_pkg::vpl_mode_t VPL_SHALLOW = vpl_pkg::VPL_SHALLOW;
	localparam vpl_pkg::vpl_mode_t VPL_DEEP    = vpl_pkg::VPL_DEEP;

	typedef struct packed {
		logic [7:0]                  pwr;
		logic [7:0]                  cause;
		logic [vpl_pkg::CLK_SEL_W-1:0] csel;
		logic [6:0]                  div;
		logic [2:0]                  stat;
		logic [2:0]                  mask;
		logic                        lv_prev;
		vpl_pkg::vpl_mode_t          mode;
		logic [7:0]                  rdata;
		logic [7:0]                  fdata;
		logic                        irq;
		logic [4:0]                  vec;
		logic                        sup_on;
		logic                        sys_rst;
		vpl_pkg::vpl_pin_t           pin;
		logic                        int_o;
	} vpl_state_t;

	vpl_state_t  st;
	vpl_state_t  next_st;
	logic [31:0] req;
	logic        req_any;
	logic [4:0]  req_idx;
	logic [15:0] slot_hi;
	logic        warn_ev;
	logic        lv_ev;
	logic        stop_ev;
	logic        lv_hit;

	// ==========================================================
	// request gating and priority
	always_comb begin
		req = SRC_FLAG_I & SRC_EN_I; // RL4
		req[vpl_pkg::VEC_WARNING] = st.pwr[vpl_pkg::BIT_WARN_FLAG] &
			st.pwr[vpl_pkg::BIT_WARN_IE]; // RL13
		req[0] = 1'b0;
	end

	vpl_prio u_prio (
		.req_i (req),
		.any_o (req_any),
		.idx_o (req_idx)
	);

	// slot address of vector n sits 2n below the top; the even fetch address is the slot
	assign slot_hi = {FETCH_ADDR_I[15:1], 1'b0}; // RL2
	// a held reset keeps the trip alive, else power-on hold would drop after one cycle
	assign lv_hit  = (st.sup_on | st.sys_rst) & LV_DETECT_I;

	// ==========================================================
	// next-state logic
	always_comb begin
		logic [1:0] sreq;
		sreq    = 2'h0;
		next_st = st;
		warn_ev = 1'b0;
		lv_ev   = 1'b0;
		stop_ev = 1'b0;
		next_st.rdata   = 8'h00;
		next_st.lv_prev = lv_hit;

		// supervisor gating
		next_st.sup_on = st.pwr[vpl_pkg::BIT_SUP_EN] &
			(st.mode == VPL_RUN || st.mode == VPL_LV_HOLD ||
			st.pwr[vpl_pkg::BIT_SUP_STOP_EN]); // RL5 RL6

		// warning flag, set wins over acknowledge
		if (WR_I && ADDR_I[3:0] == vpl_pkg::ADDR_PWR_CTRL &&
			WDATA_I[vpl_pkg::BIT_WARN_ACK])
			next_st.pwr[vpl_pkg::BIT_WARN_FLAG] = 1'b0;
		if (st.sup_on && LV_WARN_I) begin
			next_st.pwr[vpl_pkg::BIT_WARN_FLAG] = 1'b1; // RL13
			warn_ev = 1'b1;
		end

		// register writes
		if (WR_I) begin
			case (ADDR_I[3:0])
				vpl_pkg::ADDR_PWR_CTRL: begin
					next_st.pwr[5:0] = {WDATA_I[5:2], 1'b0, WDATA_I[0]};
				end
				vpl_pkg::ADDR_CLK_OUT: next_st.csel = WDATA_I[vpl_pkg::CLK_SEL_W-1:0];
				vpl_pkg::ADDR_IRQ_MASK: next_st.mask = WDATA_I[2:0];
				vpl_pkg::ADDR_STOP_REQ: sreq = WDATA_I[1:0];
				default: ;
			endcase
		end

		// mode sequencing
		case (st.mode)
			VPL_RUN: begin
				if (sreq == vpl_pkg::STOP_DEEP) begin
					stop_ev = 1'b1;
					next_st.mode = (st.pwr[vpl_pkg::BIT_SUP_EN] &&
						st.pwr[vpl_pkg::BIT_SUP_STOP_EN]) ? VPL_SHALLOW : VPL_DEEP; // RL7
				end else if (sreq == vpl_pkg::STOP_SHALLOW) begin
					stop_ev = 1'b1;
					next_st.mode = VPL_SHALLOW;
				end
			end
			VPL_SHALLOW, VPL_DEEP: begin
				if (req_any)
					next_st.mode = VPL_RUN;
			end
			VPL_LV_HOLD: begin
				if (!lv_hit)
					next_st.mode = VPL_RUN; // RL11
			end
			default: next_st.mode = VPL_RUN;
		endcase

		if (lv_hit && st.pwr[vpl_pkg::BIT_LV_RST_EN]) begin
			next_st.mode = VPL_LV_HOLD; // RL9 RL11
			// cause only rewritten on entry, so a power-on hold keeps its flags
			if (st.mode != VPL_LV_HOLD) begin
				next_st.cause = 8'h00;
				next_st.cause[vpl_pkg::BIT_CAUSE_LVR] = 1'b1; // RL12
				lv_ev = 1'b1;
				next_st.pwr = vpl_pkg::PWR_CTRL_RESET;
				next_st.csel = '0;
			end
		end
		next_st.sys_rst = (next_st.mode == VPL_LV_HOLD);

		// interrupt status: set wins over read-clear
		if (RD_I && ADDR_I[3:0] == vpl_pkg::ADDR_IRQ_STAT)
			next_st.stat = 3'h0;
		next_st.stat[vpl_pkg::EV_WARN]  = next_st.stat[vpl_pkg::EV_WARN] | warn_ev;
		next_st.stat[vpl_pkg::EV_LVRST] = next_st.stat[vpl_pkg::EV_LVRST] | lv_ev;
		next_st.stat[vpl_pkg::EV_STOP]  = next_st.stat[vpl_pkg::EV_STOP] | stop_ev;
		next_st.int_o = |(next_st.stat & next_st.mask);

		// register reads
		if (RD_I) begin
			case (ADDR_I[3:0])
				vpl_pkg::ADDR_PWR_CTRL:  next_st.rdata = {st.pwr[7], 1'b0, st.pwr[5:0]};
				vpl_pkg::ADDR_RST_CAUSE: next_st.rdata = st.cause;
				vpl_pkg::ADDR_CLK_OUT:   next_st.rdata = {5'h00, st.csel};
				vpl_pkg::ADDR_STOP_REQ:  next_st.rdata = {6'h00, st.mode};
				vpl_pkg::ADDR_IRQ_STAT:  next_st.rdata = {5'h00, st.stat};
				vpl_pkg::ADDR_IRQ_MASK:  next_st.rdata = {5'h00, st.mask};
				vpl_pkg::ADDR_VECTOR:    next_st.rdata = {2'h0, st.irq, st.vec};
				default:                 next_st.rdata = 8'h00;
			endcase
		end

		// core request and vector fetch
		next_st.irq = req_any; // RL1 RL4
		next_st.vec = req_idx;
		next_st.fdata = 8'h00;
		if (FETCH_I && FETCH_ADDR_I[15:6] == 10'h3ff) begin
			// even address is the high byte of the routine
			next_st.fdata = FETCH_ADDR_I[0] ? slot_hi[7:0] : slot_hi[15:8]; // RL3
		end

		// clock output divider
		next_st.div = st.div + 7'h01;
		next_st.pin.slew  = PIN_SLEW_EN_I; // RL17
		next_st.pin.drive = PIN_DRIVE_I;   // RL17
		if (st.csel == '0) begin
			next_st.pin.out = PORT_OUT_I; // RL14
			next_st.pin.oe  = PORT_DIR_I; // RL14
		end else begin
			next_st.pin.out = st.div[st.csel - 3'h1]; // RL16
			next_st.pin.oe  = 1'b1;                   // RL15
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			st       <= '0;
			st.pwr   <= vpl_pkg::PWR_CTRL_RESET;
			st.mode  <= VPL_RUN;
		end else if (POR_I) begin
			st       <= '0;
			st.pwr   <= vpl_pkg::PWR_CTRL_RESET;
			st.mode  <= VPL_LV_HOLD;
			st.sys_rst <= 1'b1;
			st.cause[vpl_pkg::BIT_CAUSE_POR] <= 1'b1; // RL8
			st.cause[vpl_pkg::BIT_CAUSE_LVR] <= 1'b1; // RL8
		end else begin
			st <= next_st;
		end
	end

	assign RDATA_O      = st.rdata;
	assign FETCH_DATA_O = st.fdata;
	assign CPU_IRQ_O    = st.irq;
	assign CPU_VEC_O    = st.vec;
	assign SUP_ON_O     = st.sup_on;
	assign THRESH_SEL_O = st.pwr[vpl_pkg::BIT_THRESH_SEL]; // RL10
	assign SYS_RST_O    = st.sys_rst;
	assign STOP_MODE_O  = st.mode;
	assign PIN_OUT_O    = st.pin.out;
	assign PIN_OE_O     = st.pin.oe;
	assign PIN_SLEW_O   = st.pin.slew;
	assign PIN_DRIVE_O  = st.pin.drive;
	assign INT_O        = st.int_o;

	// ==========================================================
	// checks
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (!RST_N_I);

	irq_follows_req_a: assert property ((|req && !POR_I) |=> CPU_IRQ_O) // RL4
		else $error("request not forwarded");
	warn_gate_a: assert property ((CPU_IRQ_O && CPU_VEC_O == 5'h03) |->
		$past(st.pwr[vpl_pkg::BIT_WARN_IE])) // RL13
		else $error("warning request without enable");
	sup_enable_a: assert property (SUP_ON_O |-> $past(st.pwr[vpl_pkg::BIT_SUP_EN])) // RL5
		else $error("supervisor on while disabled");
	stop_off_a: assert property ((st.mode == VPL_DEEP && !POR_I) |=> !SUP_ON_O) // RL6
		else $error("supervisor on in deep stop");
	deep_redirect_a: assert property ((st.mode == VPL_DEEP) |->
		!(st.pwr[vpl_pkg::BIT_SUP_EN] && st.pwr[vpl_pkg::BIT_SUP_STOP_EN])) // RL7
		else $error("deep stop with supervisor kept");
	por_cause_a: assert property (POR_I |=> (st.cause[7] && st.cause[1])) // RL8
		else $error("power-on cause flags missing");
	lv_reset_a: assert property ((lv_hit && st.pwr[4] && !POR_I) |=> SYS_RST_O ##0
		st.cause[1]) // RL9
		else $error("low-voltage reset missing");
	hold_a: assert property ((SYS_RST_O && lv_hit && !POR_I) |=> SYS_RST_O) // RL11
		else $error("reset released early");
	clk_out_oe_a: assert property ((st.csel != '0 && !POR_I) |=> PIN_OE_O) // RL15
		else $error("clock out pin not driven");
	port_pass_a: assert property ((st.csel == '0 && !POR_I) |=> PIN_OE_O == $past(PORT_DIR_I)) // RL14
		else $error("port direction not followed");

	cov_vec_c: cover property (CPU_IRQ_O && CPU_VEC_O == 5'h03);
	cov_redirect_c: cover property (st.mode == VPL_SHALLOW && st.pwr[3]);
	cov_lvrst_c: cover property ($rose(SYS_RST_O));
	cov_clk_c: cover property (st.csel != '0 && $rose(PIN_OUT_O));

endmodule : vpl_top

`default_nettype wire

// ===== verilog/vpl_pkg.sv
// vpl_pkg: constants, register map and carriers for the vector/supervisor/clock-out block
//
// Overview of operation
// RL1: pending sources resolve by fixed priority; reset vector outranks every source
// RL2: each source owns one two-byte vector slot, packed downward from top of memory
// RL3: vector high byte read from slot low address, low byte from next address
// RL4: flag with local enable set forwards a request; otherwise only pollable
// RL5: supervisor runs only while supervisor_enable is 1
// RL6: stop entry turns supervisor off unless supervisor_stop_enable is set
// RL7: both enables set turn a deep_stop_mode request into shallow_stop_mode
// RL8: power-on reset sets power-on and low-voltage cause flags
// RL9: low-voltage condition resets system only when low_voltage_reset_enable is 1
// RL10: threshold_select alone picks the detection threshold
// RL11: after low-voltage reset, reset held while supply stays below threshold
// RL12: low-voltage cause flag also set after a low-voltage reset
// RL13: warning sets warning_flag; request raised only with warning_interrupt_enable
// RL14: clock_out_select all zero disables clock out, pin stays port function
// RL15: nonzero clock_out_select drives divided bus clock, overriding pin direction
// RL16: divide ratio chosen by clock_out_select value
// RL17: slew and drive strength follow per-pin controls during clock out
`default_nettype none

package vpl_pkg;

	// ==========================================================
	// vector map
	localparam int          NUM_SRC     = 32;
	localparam logic [15:0] VEC_TOP     = 16'hfffe;
	localparam logic [4:0]  VEC_WARNING = 5'h03;

	// ==========================================================
	// register offsets
	localparam logic [3:0] ADDR_PWR_CTRL  = 4'h0;
	localparam logic [3:0] ADDR_RST_CAUSE = 4'h1;
	localparam logic [3:0] ADDR_CLK_OUT   = 4'h2;
	localparam logic [3:0] ADDR_STOP_REQ  = 4'h3;
	localparam logic [3:0] ADDR_IRQ_STAT  = 4'h4;
	localparam logic [3:0] ADDR_IRQ_MASK  = 4'h5;
	localparam logic [3:0] ADDR_VECTOR    = 4'h6;

	// ==========================================================
	// power_mgmt_control_1 fields
	localparam int BIT_WARN_FLAG   = 7;
	localparam int BIT_WARN_ACK    = 6;
	localparam int BIT_WARN_IE     = 5;
	localparam int BIT_LV_RST_EN   = 4;
	localparam int BIT_SUP_STOP_EN = 3;
	localparam int BIT_SUP_EN      = 2;
	localparam int BIT_THRESH_SEL  = 0;
	localparam logic [7:0] PWR_CTRL_RESET = 8'h1c;

	// reset_cause_register fields
	localparam int BIT_CAUSE_POR = 7;
	localparam int BIT_CAUSE_LVR = 1;

	// interrupt status bits
	localparam int EV_WARN  = 0;
	localparam int EV_LVRST = 1;
	localparam int EV_STOP  = 2;

	// ==========================================================
	// clock divider: ratio is 2 ^ clock_out_select
	localparam int          CLK_SEL_W = 3;
	localparam logic [6:0] DIV_RESET = 7'h00;

	// stop request encodings
	localparam logic [1:0] STOP_NONE    = 2'h0;
	localparam logic [1:0] STOP_SHALLOW = 2'h1;
	localparam logic [1:0] STOP_DEEP    = 2'h2;

	typedef enum logic [1:0] {
		VPL_RUN,
		VPL_LV_HOLD,
		VPL_SHALLOW,
		VPL_DEEP
	} vpl_mode_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} vpl_bus_t;

	typedef struct packed {
		logic       out;
		logic       oe;
		logic       slew;
		logic       drive;
	} vpl_pin_t;

endpackage : vpl_pkg

`default_nettype wire

// ===== verilog/vpl_prio.sv
// vpl_prio: fixed-priority encoder returning the winning source number
`default_nettype none

module vpl_prio (
	// request vector
	input  wire logic [vpl_pkg::NUM_SRC-1:0] req_i,
	// result
	output logic                             any_o,
	output logic [4:0]                       idx_o
);
	always_comb begin
		any_o = 1'b0;
		idx_o = 5'h1f;
		// lowest number wins: vector 0 is the top slot
		for (int i = vpl_pkg::NUM_SRC - 1; i >= 0; i--) begin
			if (req_i[i]) begin
				any_o = 1'b1; // RL1
				idx_o = 5'(i);
			end
		end
	end
endmodule : vpl_prio

`default_nettype wire

// ===== verilog/vpl_types_fix.sv
// unused

// ===== bench/vpl_partner.sv
// vpl_partner: behavioural analog supply monitor facing the supervisor control
`default_nettype none

module vpl_partner (
	// supervisor control from the block
	input  wire logic sup_on_i,
	input  wire logic sys_rst_i,
	// supply conditions set by the bench
	input  wire logic supply_low_i,
	input  wire logic supply_warn_i,
	input  wire logic power_up_i,
	// trip indications
	output logic      por_o,
	output logic      lv_detect_o,
	output logic      lv_warn_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// comparators
	// unpowered comparators never trip; a held reset keeps the low trip alive
	assign lv_detect_o = supply_low_i & (sup_on_i | sys_rst_i);
	assign lv_warn_o   = supply_warn_i & sup_on_i;
	assign por_o       = power_up_i;
endmodule : vpl_partner

`default_nettype wire

// ===== bench/vpl_top_tb_top.sv
// vpl_top_tb_top: self-checking bench for the vector/supervisor/clock-out block
`default_nettype none
`define CHK(nm, ex, sn) begin \
	tests_run++; \
	if ((sn) !== (ex)) begin \
		mismatches++; \
		$display("CHECK FAILED %s expected %h seen %h", nm, ex, sn); \
	end \
end

module vpl_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// stimulus and observation
	logic        clk = 1'b0, rst_n = 1'b0;
	logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata, rv, fdata;
	logic        wr = 1'b0, rd = 1'b0, fetch = 1'b0;
	logic [31:0] src_flag = 32'h0, src_en = 32'h0;
	logic [15:0] fetch_addr = 16'hffc0;
	logic        supply_low = 1'b0, supply_warn = 1'b0, power_up = 1'b0;
	logic        port_out = 1'b0, port_dir = 1'b0, slew = 1'b0, drive = 1'b0;
	logic        cpu_irq, sup_on, thresh, sys_rst, pin_out, pin_oe, pin_slew;
	logic        pin_drive, int_o, por, lv_det, lv_warn, last;
	logic [4:0]  cpu_vec;
	logic [1:0]  stop_mode;
	int          mismatches = 0, tests_run = 0, cycles = 0, tog;

	always #20 clk = ~clk;

	vpl_top i_dut (.CORE_CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
		.WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .SRC_FLAG_I(src_flag), .SRC_EN_I(src_en),
		.FETCH_ADDR_I(fetch_addr), .FETCH_I(fetch), .FETCH_DATA_O(fdata),
		.CPU_IRQ_O(cpu_irq), .CPU_VEC_O(cpu_vec), .POR_I(por), .LV_DETECT_I(lv_det),
		.LV_WARN_I(lv_warn), .SUP_ON_O(sup_on), .THRESH_SEL_O(thresh),
		.SYS_RST_O(sys_rst), .STOP_MODE_O(stop_mode), .PORT_OUT_I(port_out),
		.PORT_DIR_I(port_dir), .PIN_SLEW_EN_I(slew), .PIN_DRIVE_I(drive),
		.PIN_OUT_O(pin_out), .PIN_OE_O(pin_oe), .PIN_SLEW_O(pin_slew),
		.PIN_DRIVE_O(pin_drive), .INT_O(int_o));

	vpl_partner i_partner (.sup_on_i(sup_on), .sys_rst_i(sys_rst),
		.supply_low_i(supply_low), .supply_warn_i(supply_warn), .power_up_i(power_up),
		.por_o(por), .lv_detect_o(lv_det), .lv_warn_o(lv_warn));

	// ==========================================================
	// bus tasks
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		// let an edge pass so a following call never re-drives wr in this step
		@(posedge clk);
	endtask : wr_reg

	// read data stands only in the cycle after the strobe
	task automatic rd_reg(input logic [7:0] a);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 rv = rdata;
		@(posedge clk);
	endtask : rd_reg

	task automatic fetch_byte(input logic [15:0] a);
		fetch_addr <= a;
		fetch <= 1'b1;
		@(posedge clk);
		fetch <= 1'b0;
		#1 rv = fdata;
		@(posedge clk);
	endtask : fetch_byte

	task automatic report_and_stop();
		if (mismatches == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : report_and_stop

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			report_and_stop();
		end
	end

	// ==========================================================
	// scenarios
	initial begin
		cyc(3);
		rst_n <= 1'b1;
		cyc(3);
		`CHK("sup_on", 1'b1, sup_on)
		rd_reg(8'h00);
		`CHK("pwr", 8'h1c, rv)
		rd_reg(8'h0f);
		`CHK("unmapped", 8'h00, rv)
		// power-up with supply still low: reset outlives the power-on pulse
		power_up <= 1'b1;
		supply_low <= 1'b1;
		cyc(3);
		power_up <= 1'b0;
		cyc(4);
		`CHK("por_hold", 1'b1, sys_rst)
		supply_low <= 1'b0;
		cyc(4);
		`CHK("por_free", 1'b0, sys_rst)
		rd_reg(8'h01);
		`CHK("cause_por", 8'h82, rv)
		supply_low <= 1'b1;
		cyc(6);
		`CHK("lv_hold", 1'b1, sys_rst)
		supply_low <= 1'b0;
		cyc(4);
		`CHK("lv_free", 1'b0, sys_rst)
		rd_reg(8'h01);
		`CHK("cause_lv", 8'h02, rv)
		wr_reg(8'h00, 8'h0c);
		supply_low <= 1'b1;
		cyc(6);
		`CHK("lv_no_rst", 1'b0, sys_rst)
		supply_low <= 1'b0;
		wr_reg(8'h00, 8'h0d);
		cyc(2);
		`CHK("thresh", 1'b1, thresh)
		wr_reg(8'h00, 8'h08);
		cyc(2);
		`CHK("thresh_off", 1'b0, thresh)
		`CHK("sup_off", 1'b0, sup_on)
		// stop entries: deep request with both enables lands in shallow
		wr_reg(8'h00, 8'h0c);
		wr_reg(8'h03, 8'h02);
		cyc(2);
		`CHK("stop_keep", 2'h2, stop_mode)
		`CHK("sup_stop_on", 1'b1, sup_on)
		for (int k = 0; k < 3; k++) begin
			src_flag <= 32'h20;
			src_en <= 32'h20;
			cyc(3);
			`CHK("wake", 2'h0, stop_mode)
			src_flag <= 32'h0;
			wr_reg(8'h00, 8'h04);
			wr_reg(8'h03, (k == 0) ? 8'h02 : 8'h01);
			cyc(2);
			`CHK("stop_mode", (k == 0) ? 2'h3 : 2'h2, stop_mode)
			`CHK("sup_stop_off", 1'b0, sup_on)
		end
		src_flag <= 32'h20;
		cyc(3);
		src_flag <= 32'h0;
		src_en <= 32'h0;
		// warning with and without its interrupt enable
		wr_reg(8'h00, 8'h24);
		rd_reg(8'h04);
		supply_warn <= 1'b1;
		cyc(3);
		supply_warn <= 1'b0;
		cyc(2);
		`CHK("warn_irq", 1'b1, cpu_irq)
		`CHK("warn_vec", 5'h03, cpu_vec)
		rd_reg(8'h00);
		`CHK("warn_flag", 8'ha4, rv)
		wr_reg(8'h05, 8'h01);
		cyc(2);
		`CHK("int_on", 1'b1, int_o)
		rd_reg(8'h04);
		`CHK("status", 8'h01, rv)
		cyc(2);
		`CHK("int_off", 1'b0, int_o)
		wr_reg(8'h00, 8'h64);
		wr_reg(8'h00, 8'h04);
		supply_warn <= 1'b1;
		cyc(3);
		supply_warn <= 1'b0;
		cyc(2);
		`CHK("warn_poll", 1'b0, cpu_irq)
		rd_reg(8'h00);
		`CHK("warn_flag2", 8'h84, rv)
		wr_reg(8'h00, 8'h44);
		// priority: lowest vector number wins; disabled flags only pollable
		src_en <= 32'hffffffff;
		for (int n = 1; n < 31; n++) begin
			if (n != 3) begin
				src_flag <= (32'h1 << n) | 32'h80000000;
				cyc(3);
				`CHK("vec", 5'(n), cpu_vec)
			end
		end
		src_en <= 32'h80000000;
		cyc(3);
		`CHK("vec_en", 5'h1f, cpu_vec)
		src_en <= 32'h0;
		cyc(3);
		`CHK("irq_en", 1'b0, cpu_irq)
		src_flag <= 32'h0;
		for (int n = 0; n < 32; n++) begin
			fetch_byte(16'hfffe - 16'(2 * n));
			`CHK("vec_hi", 8'hff, rv)
			fetch_byte(16'hffff - 16'(2 * n));
			`CHK("vec_lo", 8'hfe - 8'(2 * n), rv)
		end
		// clock output on the shared pin
		wr_reg(8'h02, 8'h00);
		port_out <= 1'b1;
		cyc(3);
		`CHK("pin_oe_off", 1'b0, pin_oe)
		`CHK("pin_port", 1'b1, pin_out)
		slew <= 1'b1;
		drive <= 1'b1;
		for (int s = 1; s < 8; s++) begin
			wr_reg(8'h02, 8'(s));
			cyc(4);
			#1 last = pin_out;
			tog = 0;
			repeat (128) begin
				@(posedge clk);
				#1 tog += int'(pin_out !== last);
				last = pin_out;
			end
			`CHK("toggles", 256 >> s, tog)
			`CHK("pin_oe_on", 1'b1, pin_oe)
		end
		`CHK("pin_slew", 1'b1, pin_slew)
		`CHK("pin_drive", 1'b1, pin_drive)
		report_and_stop();
	end
endmodule : vpl_top_tb_top

`undef CHK
`default_nettype wire
